// >>> rtl/drive_security_defines.svh
// opcodes, parameter sector layout, register bits and reset values
// assumes: included by bare name from the security lock design files
`ifndef DRIVE_SECURITY_DEFINES_SVH
`define DRIVE_SECURITY_DEFINES_SVH

// ****************************************
// command opcodes
// ****************************************
`define OPC_SET_PASSWORD 8'hF1
`define OPC_UNLOCK 8'hF2
`define OPC_ERASE_PREPARE 8'hF3
`define OPC_ERASE_UNIT 8'hF4
`define OPC_FREEZE 8'hF5
`define OPC_DISABLE_PASSWORD 8'hF6

// ****************************************
// parameter sector layout
// ****************************************
`define SECTOR_WORDS 9'h100
`define PW_FIRST_WORD 9'h001
`define PW_LAST_WORD 9'h010
`define REV_WORD 9'h011
`define CTL_IDENT_BIT 0
`define CTL_LEVEL_BIT 8

// ****************************************
// security state values
// ****************************************
`define ATTEMPTS_INIT 3'h5
`define ATTEMPTS_NONE 3'h0
`define REV_DEFAULT 16'hFFFE
`define REV_RESERVED 16'hFFFF

// ****************************************
// error and status register bits
// ****************************************
`define ERR_ABT_BIT 2
`define ST_BSY_BIT 7
`define ST_RDY_BIT 6
`define ST_DSC_BIT 4
`define ST_DRQ_BIT 3
`define ST_ERR_BIT 0
`define STATUS_RESET 8'h50
`define ERROR_RESET 8'h00

`endif

// >>> rtl/drive_security_lock_fsm.sv
// security lock command handling: freeze, set password, unlock, erase
// assumes: task-file commands and data words from logic on clock_in;
// sys_rst_in is power loss, hard_reset_in a one-cycle reset event
`timescale 1ns/1ps
`include "drive_security_defines.svh"

// Summary of operation
// - freeze command sets frozen at once, no data
// - frozen rejects set, unlock, disable, erase
// - only power loss clears frozen
// - set password takes one sector before acting
// - user password enables lock, locks next reset
// - master password stored, lock left unchanged
// - word 0: bit 0 identifier, bit 8 level
// - all 32 password bytes stored and compared
// - master set stores word 17 revision code
// - revision default FFFEh, FFFFh reserved
// - high level unlocks by user or master
// - maximum level refuses master, keeps it stored
// - maximum level: erase only removes lost lock
// - unlock clears lock until next reset
// - master unlock compares at high, rejected at maximum
// - user unlock compares all 32 bytes
// - mismatch aborts and decrements attempt counter
// - counter starts five, zero rejects protected commands
// - abort after sector only on failed unlock: mismatch or master at maximum
module drive_security_lock_fsm (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic hard_reset_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  output logic cmd_ready_out,
  input wire logic data_valid_in,
  input wire logic [15:0] data_word_in,
  output logic [7:0] error_reg_out,
  output logic [7:0] status_reg_out,
  output logic cmd_done_out,
  output logic [15:0] master_rev_out,
  output logic frozen_out,
  output logic locked_out,
  output logic lock_enabled_out,
  output logic security_max_out,
  output logic [2:0] attempts_left_out,
  output logic erase_start_out
);
  import drive_security_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // commands that carry a parameter sector
  function automatic logic needs_sector(input logic [7:0] op);
    return op == `OPC_SET_PASSWORD || op == `OPC_UNLOCK || op == `OPC_ERASE_UNIT;
  endfunction : needs_sector

  // commands refused once attempts run out or while frozen
  function automatic logic pw_protected(input logic [7:0] op);
    return needs_sector(op) || op == `OPC_DISABLE_PASSWORD;
  endfunction : pw_protected

  // status byte with ready and seek complete always set when idle
  function automatic logic [7:0] make_status(input logic bsy, input logic drq,
                                             input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[`ST_BSY_BIT] = bsy;
    s[`ST_RDY_BIT] = !bsy;
    s[`ST_DSC_BIT] = !bsy;
    s[`ST_DRQ_BIT] = drq;
    s[`ST_ERR_BIT] = err;
    return s;
  endfunction : make_status

  // ****************************************
  // declarations
  // ****************************************
  sec_state_type state;
  logic [7:0] cur_op;
  logic abort_pending;
  logic erase_armed;
  logic [255:0] user_pw;
  logic [255:0] master_pw;
  logic rx_done;
  logic [15:0] rx_control;
  logic [255:0] rx_pw;
  logic [15:0] rx_rev;
  logic accept;
  logic early_reject;
  logic known_op;
  logic sel_master;
  logic req_max;
  logic exec;
  logic unlock_refused;
  logic unlock_match;
  logic exec_abort;

  // ****************************************
  // command acceptance and early rejection
  // ****************************************
  assign cmd_ready_out = (state == ST_IDLE);
  assign accept = cmd_valid_in && cmd_ready_out && !hard_reset_in;
  assign known_op = pw_protected(cmd_code_in) || cmd_code_in == `OPC_FREEZE ||
                    cmd_code_in == `OPC_ERASE_PREPARE;

  // rejections decided before any data phase
  always_comb begin
    early_reject = !known_op;
    if (pw_protected(cmd_code_in) && frozen_out) begin
      early_reject = 1'b1;
    end
    if (pw_protected(cmd_code_in) && attempts_left_out == `ATTEMPTS_NONE) begin
      early_reject = 1'b1;
    end
    if (cmd_code_in == `OPC_SET_PASSWORD && locked_out) begin
      early_reject = 1'b1;
    end
    if (cmd_code_in == `OPC_ERASE_UNIT && !erase_armed) begin
      early_reject = 1'b1;
    end
    if (cmd_code_in == `OPC_DISABLE_PASSWORD) begin
      early_reject = 1'b1;
    end
  end

  // ****************************************
  // sector decode and password checks
  // ****************************************
  assign exec = (state == ST_EXEC);
  assign sel_master = rx_control[`CTL_IDENT_BIT];
  assign req_max = rx_control[`CTL_LEVEL_BIT];
  assign unlock_refused = sel_master && security_max_out;
  // full 256-bit compare against the selected password
  assign unlock_match = !unlock_refused &&
                        (sel_master ? rx_pw == master_pw : rx_pw == user_pw);
  assign exec_abort = (cur_op == `OPC_UNLOCK) && !unlock_match;

  param_sector_rx sector_rx (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(accept),
    .word_valid_in(data_valid_in && state == ST_DATA),
    .word_in(data_word_in),
    .sector_done_out(rx_done),
    .control_out(rx_control),
    .password_out(rx_pw),
    .revision_out(rx_rev)
  );

  // ****************************************
  // command sequencer
  // ****************************************

  // idle, sector transfer, execute, finish
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      cur_op <= 8'h00;
      abort_pending <= 1'b0;
    end else if (hard_reset_in) begin
      state <= ST_IDLE;
      abort_pending <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            cur_op <= cmd_code_in;
            abort_pending <= early_reject;
            if (early_reject || !needs_sector(cmd_code_in)) begin
              state <= ST_FINISH;
            end else begin
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (rx_done) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          abort_pending <= exec_abort;
          state <= ST_FINISH;
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // error and status bytes, done and erase pulses
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_reg_out <= `STATUS_RESET;
      error_reg_out <= `ERROR_RESET;
      cmd_done_out <= 1'b0;
      erase_start_out <= 1'b0;
    end else if (hard_reset_in) begin
      status_reg_out <= `STATUS_RESET;
      error_reg_out <= `ERROR_RESET;
      cmd_done_out <= 1'b0;
      erase_start_out <= 1'b0;
    end else begin
      cmd_done_out <= (state == ST_FINISH);
      erase_start_out <= exec && cur_op == `OPC_ERASE_UNIT;
      if (accept) begin
        error_reg_out <= `ERROR_RESET;
        if (early_reject || !needs_sector(cmd_code_in)) begin
          status_reg_out <= make_status(1'b1, 1'b0, 1'b0);
        end else begin
          status_reg_out <= make_status(1'b0, 1'b1, 1'b0);
        end
      end else if (state == ST_DATA && rx_done) begin
        status_reg_out <= make_status(1'b1, 1'b0, 1'b0);
      end else if (state == ST_FINISH) begin
        status_reg_out <= make_status(1'b0, 1'b0, abort_pending);
        error_reg_out[`ERR_ABT_BIT] <= abort_pending;
      end
    end
  end

  // ****************************************
  // security state
  // ****************************************

  // frozen: only power loss brings it back down
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frozen_out <= 1'b0;
    end else if (accept && cmd_code_in == `OPC_FREEZE) begin
      frozen_out <= 1'b1;
    end
  end

  // erase unit must follow erase prepare directly
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      erase_armed <= 1'b0;
    end else if (hard_reset_in) begin
      erase_armed <= 1'b0;
    end else if (accept) begin
      erase_armed <= (cmd_code_in == `OPC_ERASE_PREPARE);
    end
  end

  // unlock attempt counter
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      attempts_left_out <= `ATTEMPTS_INIT;
    end else if (hard_reset_in) begin
      attempts_left_out <= `ATTEMPTS_INIT;
    end else if (exec && exec_abort && !unlock_refused &&
                 attempts_left_out != `ATTEMPTS_NONE) begin
      attempts_left_out <= attempts_left_out - 3'h1;
    end
  end

  // lock enable, level and locked mode
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lock_enabled_out <= 1'b0;
      security_max_out <= 1'b0;
      locked_out <= 1'b0;
    end else if (hard_reset_in) begin
      locked_out <= lock_enabled_out;
    end else if (exec) begin
      if (cur_op == `OPC_SET_PASSWORD && !sel_master) begin
        lock_enabled_out <= 1'b1;
        security_max_out <= req_max;
      end
      if (cur_op == `OPC_UNLOCK && unlock_match) begin
        locked_out <= 1'b0;
      end
      if (cur_op == `OPC_ERASE_UNIT) begin
        lock_enabled_out <= 1'b0;
        security_max_out <= 1'b0;
        locked_out <= 1'b0;
      end
    end
  end

  // stored passwords and master revision code
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      user_pw <= 256'h0;
      master_pw <= 256'h0;
      master_rev_out <= `REV_DEFAULT;
    end else if (exec && cur_op == `OPC_SET_PASSWORD) begin
      if (sel_master) begin
        master_pw <= rx_pw;
        if (rx_rev != `REV_RESERVED) begin
          master_rev_out <= rx_rev;
        end
      end else begin
        user_pw <= rx_pw;
      end
    end else if (exec && cur_op == `OPC_ERASE_UNIT) begin
      user_pw <= 256'h0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence seq_taken(logic [7:0] op);
    accept && cmd_code_in == op ##1 !hard_reset_in;
  endsequence

  sequence seq_abort_shown;
    status_reg_out[`ST_ERR_BIT] && error_reg_out[`ERR_ABT_BIT] &&
    !status_reg_out[`ST_BSY_BIT] && status_reg_out[`ST_RDY_BIT];
  endsequence

  AST_FREEZE_SETS: assert property (
    accept && cmd_code_in == `OPC_FREEZE |=> frozen_out && state == ST_FINISH)
    else $error("freeze did not set frozen at once");

  AST_FROZEN_HOLDS: assert property (
    frozen_out |=> frozen_out)
    else $error("frozen state left without power loss");

  AST_FROZEN_REJECT: assert property (
    frozen_out ##0 seq_taken(`OPC_UNLOCK) |=> seq_abort_shown and cmd_done_out)
    else $error("unlock not aborted while frozen");

  AST_SECTOR_FIRST: assert property (
    state == ST_EXEC |-> $past(rx_done) && $past(state == ST_DATA))
    else $error("command acted before its sector arrived");

  AST_USER_LOCK_LATER: assert property (
    exec && cur_op == `OPC_SET_PASSWORD && !sel_master && !hard_reset_in
    |=> lock_enabled_out && locked_out == $past(locked_out))
    else $error("user password did not enable lock correctly");

  AST_MASTER_KEEPS_LOCK: assert property (
    exec && cur_op == `OPC_SET_PASSWORD && sel_master && rx_rev != `REV_RESERVED
    |=> lock_enabled_out == $past(lock_enabled_out) && master_rev_out == $past(rx_rev))
    else $error("master password set changed lock or lost revision");

  AST_MISMATCH_DECR: assert property (
    exec && cur_op == `OPC_UNLOCK && !unlock_match && !unlock_refused && !hard_reset_in &&
    attempts_left_out != `ATTEMPTS_NONE
    |=> attempts_left_out == $past(attempts_left_out) - 3'h1 ##1 seq_abort_shown)
    else $error("mismatch did not decrement and abort");

  AST_ZERO_ATTEMPTS: assert property (
    attempts_left_out == `ATTEMPTS_NONE ##0 seq_taken(`OPC_UNLOCK)
    |=> seq_abort_shown)
    else $error("unlock taken with no attempts left");

  AST_MAX_MASTER: assert property (
    exec && cur_op == `OPC_UNLOCK && sel_master && security_max_out && !hard_reset_in
    |=> locked_out == $past(locked_out) ##1 seq_abort_shown)
    else $error("master accepted at maximum level");

  AST_RELOCK: assert property (
    hard_reset_in |=> locked_out == $past(lock_enabled_out) &&
    attempts_left_out == `ATTEMPTS_INIT)
    else $error("reset did not restore lock and counter");

endmodule : drive_security_lock_fsm

// >>> rtl/drive_security_pkg.sv
// types shared by the security lock command block
// assumes: nothing beyond the standard language
package drive_security_pkg;

  // one-hot command sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DATA = 4'h2,
    ST_EXEC = 4'h4,
    ST_FINISH = 4'h8
  } sec_state_type;

endpackage : drive_security_pkg

// >>> rtl/param_sector_rx.sv
// parameter sector receiver: 256 words, keeps control, password, revision
// assumes: words arrive on clock_in from logic in the same domain
`timescale 1ns/1ps
`include "drive_security_defines.svh"

module param_sector_rx (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic word_valid_in,
  input wire logic [15:0] word_in,
  output logic sector_done_out,
  output logic [15:0] control_out,
  output logic [255:0] password_out,
  output logic [15:0] revision_out
);

  logic [8:0] word_index;
  logic [15:0] pw_words [0:15];

  // word counter, restarted by each new command
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_index <= 9'h000;
    end else if (start_in) begin
      word_index <= 9'h000;
    end else if (word_valid_in && word_index != `SECTOR_WORDS) begin
      word_index <= word_index + 9'h001;
    end
  end

  // one-cycle pulse after the last word of the sector
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sector_done_out <= 1'b0;
    end else begin
      sector_done_out <= word_valid_in && (word_index == `SECTOR_WORDS - 9'h001);
    end
  end

  // capture of the meaningful words, reserved words dropped
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      control_out <= 16'h0000;
      revision_out <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        pw_words[i] <= 16'h0000;
      end
    end else if (word_valid_in) begin
      if (word_index == 9'h000) begin
        control_out <= word_in;
      end
      if (word_index >= `PW_FIRST_WORD && word_index <= `PW_LAST_WORD) begin
        pw_words[4'(word_index - `PW_FIRST_WORD)] <= word_in;
      end
      if (word_index == `REV_WORD) begin
        revision_out <= word_in;
      end
    end
  end

  // all 32 bytes laid out as one vector, first word lowest
  always_comb begin
    password_out = 256'h0;
    for (int i = 0; i < 16; i++) begin
      password_out[i*16 +: 16] = pw_words[i];
    end
  end

endmodule : param_sector_rx

// >>> testbench/drive_security_lock_fsm_tb.sv
// bench for the security lock block, host model on the command side
// assumes: design files and the defines header are compiled first
`timescale 1ns/1ps
`include "drive_security_defines.svh"

module drive_security_lock_fsm_tb;
  localparam logic [255:0] PM = {8{32'h1357_9BDF}};
  localparam logic [255:0] PU = {8{32'h2468_ACE0}};
  localparam logic [255:0] PU2 = {8{32'hFEDC_BA98}};
  localparam logic [255:0] TOP = {1'b1, 255'h0};
  logic clock_in, sys_rst_in, hard_reset_in, cmd_valid, cmd_ready, data_valid, cmd_done;
  logic frozen, locked, lock_en, sec_max, erase_start;
  logic [7:0] cmd_code, error_reg, status_reg;
  logic [15:0] data_word, master_rev;
  logic [2:0] attempts;
  int fail_count, num_checks;
  int erase_count = 0;
  logic [7:0] frozen_codes [4] = '{8'hF1, 8'hF2, 8'hF4, 8'hF6};

  drive_security_lock_fsm u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .hard_reset_in(hard_reset_in), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
    .cmd_ready_out(cmd_ready), .data_valid_in(data_valid), .data_word_in(data_word),
    .error_reg_out(error_reg), .status_reg_out(status_reg), .cmd_done_out(cmd_done),
    .master_rev_out(master_rev), .frozen_out(frozen), .locked_out(locked),
    .lock_enabled_out(lock_en), .security_max_out(sec_max), .attempts_left_out(attempts),
    .erase_start_out(erase_start));

  sec_host_model u_host (.clock_in(clock_in), .cmd_ready_in(cmd_ready),
    .cmd_done_in(cmd_done), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
    .data_valid_out(data_valid), .data_word_out(data_word));

  // 10 MHz clock and erase pulse counter
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) if (erase_start === 1'b1) erase_count++;

  // ****************************************
  // compare, report and close
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic cmd(input logic [7:0] code, input logic data, input logic [15:0] ctl,
                     input logic [255:0] pw, input logic [15:0] rev, input int gap,
                     input logic [7:0] exp_st);
    int exp_cyc;
    // done is seen one edge after the finish state, three after the last word
    exp_cyc = data ? 4 + 255 * (gap + 1) : 1;
    u_host.run(code, data, ctl, pw, rev, gap);
    if (u_host.cycles == 0) begin
      fail_count++;
      conclude();
    end else begin
      check("cycles", 16'(u_host.cycles), 16'(exp_cyc));
      check("status", 16'(status_reg), 16'(exp_st));
      check("error", 16'(error_reg), exp_st[0] ? 16'h0004 : 16'h0000);
    end
  endtask : cmd

  task automatic hreset;
    hard_reset_in = 1'b1;
    @(posedge clock_in);
    #1;
    hard_reset_in = 1'b0;
  endtask : hreset

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fail_count = 0;
    num_checks = 0;
    hard_reset_in = 1'b0;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    check("rev", master_rev, 16'hFFFE);
    check("attempts", 16'(attempts), 16'h0005);
    cmd(8'hA5, 1'b0, 16'h0000, PU, 16'h0000, 0, 8'h51);
    cmd(8'hF1, 1'b1, 16'h0101, PM, 16'h1234, 0, 8'h50);
    check("rev", master_rev, 16'h1234);
    check("lock_en", 16'(lock_en), 16'h0000);
    cmd(8'hF1, 1'b1, 16'h0001, PM, 16'hFFFD, 0, 8'h50);
    check("rev", master_rev, 16'hFFFD);
    cmd(8'hF1, 1'b1, 16'hFEFE, PU, 16'h5555, 0, 8'h50);
    check("lock_en", 16'(lock_en), 16'h0001);
    check("locked", 16'(locked), 16'h0000);
    check("max", 16'(sec_max), 16'h0000);
    check("rev", master_rev, 16'hFFFD);
    hreset();
    check("locked", 16'(locked), 16'h0001);
    cmd(8'hF2, 1'b1, 16'h0000, PU ^ TOP, 16'h0000, 0, 8'h51);
    check("attempts", 16'(attempts), 16'h0004);
    cmd(8'hF2, 1'b1, 16'h0001, PM, 16'h0000, 0, 8'h50);
    check("locked", 16'(locked), 16'h0000);
    hreset();
    check("locked", 16'(locked), 16'h0001);
    check("attempts", 16'(attempts), 16'h0005);
    cmd(8'hF2, 1'b1, 16'h0000, PU, 16'h0000, 2, 8'h50);
    check("locked", 16'(locked), 16'h0000);
    cmd(8'hF1, 1'b1, 16'h0100, PU2, 16'h0000, 0, 8'h50);
    check("max", 16'(sec_max), 16'h0001);
    hreset();
    cmd(8'hF2, 1'b1, 16'h0001, PM, 16'h0000, 0, 8'h51);
    check("rev", master_rev, 16'hFFFD);
    check("locked", 16'(locked), 16'h0001);
    check("attempts", 16'(attempts), 16'h0005);
    cmd(8'hF4, 1'b0, 16'h0000, PU2, 16'h0000, 0, 8'h51);
    cmd(8'hF3, 1'b0, 16'h0000, PU2, 16'h0000, 0, 8'h50);
    cmd(8'hF4, 1'b1, 16'h0000, PU, 16'h0000, 0, 8'h50);
    check("erase", 16'(erase_count), 16'h0001);
    check("lock_en", 16'(lock_en), 16'h0000);
    cmd(8'hF1, 1'b1, 16'h0000, PU, 16'h0000, 0, 8'h50);
    hreset();
    for (int i = 0; i < 5; i++) begin
      cmd(8'hF2, 1'b1, 16'h0000, PM, 16'h0000, 0, 8'h51);
    end
    check("attempts", 16'(attempts), 16'h0000);
    cmd(8'hF2, 1'b0, 16'h0000, PU, 16'h0000, 0, 8'h51);
    hreset();
    check("attempts", 16'(attempts), 16'h0005);
    cmd(8'hF5, 1'b0, 16'h0000, PU, 16'h0000, 0, 8'h50);
    check("frozen", 16'(frozen), 16'h0001);
    foreach (frozen_codes[i]) begin
      cmd(frozen_codes[i], 1'b0, 16'h0000, PU, 16'h0000, 0, 8'h51);
    end
    hreset();
    check("frozen", 16'(frozen), 16'h0001);
    sys_rst_in = 1'b1;
    @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    check("frozen", 16'(frozen), 16'h0000);
    conclude();
  end

endmodule : drive_security_lock_fsm_tb

// >>> testbench/sec_host_model.sv
// host side model: presents security commands and their parameter sector
// assumes: bench calls run() one command at a time, shortly after an edge
`timescale 1ns/1ps

module sec_host_model (
  input wire logic clock_in,
  input wire logic cmd_ready_in,
  input wire logic cmd_done_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out,
  output logic data_valid_out,
  output logic [15:0] data_word_out
);
  int cycles;

  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    cycles = 0;
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
    data_valid_out = 1'b0;
    data_word_out = 16'h0000;
  end

  // one sector of 256 words, gap idle cycles after each word
  task automatic send_sector(input logic [15:0] ctl, input logic [255:0] pw,
                             input logic [15:0] rev, input int gap);
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin  // exactly one sector
      w = (i == 0) ? ctl : (i <= 16) ? pw[16*(i-1) +: 16] : (i == 17) ? rev : 16'h0000;
      data_valid_out = 1'b1;
      data_word_out = w;  // revision word as given
      @(posedge clock_in);
      #1;
      if (gap > 0 || i == 255) begin
        data_valid_out = 1'b0;
        data_word_out = ~w;  // released bus does not hold its value
        repeat (gap) @(posedge clock_in);
        #1;
      end
    end
  endtask : send_sector

  // ****************************************
  // command: hold until taken, then sector and completion in parallel
  // ****************************************
  task automatic run(input logic [7:0] code, input logic data, input logic [15:0] ctl,
                     input logic [255:0] pw, input logic [15:0] rev, input int gap);
    logic taken;
    taken = 1'b0;
    cycles = 0;
    cmd_valid_out = 1'b1;
    cmd_code_out = code;
    for (int n = 0; n < 50 && !taken; n++) begin
      @(posedge clock_in);
      taken = cmd_ready_in;
    end
    #1;
    cmd_valid_out = 1'b0;
    cmd_code_out = ~code;
    if (taken) begin
      fork
        if (data) send_sector(ctl, pw, rev, gap);
        for (int n = 1; n < 2000 && cycles == 0; n++) begin
          @(posedge clock_in);
          #1;
          if (cmd_done_in === 1'b1) cycles = n;  // abort before or after data
        end
      join
    end
  endtask : run

endmodule : sec_host_model
